/* File: pkg/pcir_pkg.sv */
// Package for the power controller input word bank.
// Assumes one 125 MHz clock domain and a 16-bit fieldbus word read port.
package pcir_pkg;

  // ------------------------------------------------------------------
  // Word geometry
  // ------------------------------------------------------------------
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned NUM_WORDS = 10;

  // Word offsets of the input bank; byte offset is twice the word offset.
  localparam logic [ADDR_W-1:0] OFS_RSVD0     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RSVD1     = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_LINE_FREQ = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_OUT_VOLT  = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_OUT_CURR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT_POWER = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_CMD_RB    = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_SETPOINT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SCALE     = 8'h09;
  localparam int unsigned       BYTE_SHIFT    = 1;

  // ------------------------------------------------------------------
  // Upper limits of each parameter word; the lower limit is zero.
  // ------------------------------------------------------------------
  localparam logic [WORD_W-1:0] MAX_LINE_FREQ = 16'hFFFF;
  localparam logic [WORD_W-1:0] MAX_OUT_VOLT  = 16'h270F;
  localparam logic [WORD_W-1:0] MAX_OUT_CURR  = 16'h270F;
  localparam logic [WORD_W-1:0] MAX_OUT_POWER = 16'h0064;
  localparam logic [WORD_W-1:0] MAX_SETPOINT  = 16'h03FF;
  localparam logic [WORD_W-1:0] MAX_SCALE     = 16'h00FF;

  // ------------------------------------------------------------------
  // Status word bit positions
  // ------------------------------------------------------------------
  localparam int unsigned ST_SHORTED_THYR = 0;
  localparam int unsigned ST_HEATER_BREAK = 1;
  localparam int unsigned ST_OUT_ENABLED  = 2;
  localparam int unsigned ST_CURR_LIMIT   = 4;
  localparam int unsigned ST_THERMAL      = 5;
  localparam int unsigned ST_COMM_ALARM   = 6;
  localparam int unsigned ST_DIG_IN1      = 8;
  localparam int unsigned ST_DIG_IN2      = 9;
  localparam int unsigned ST_UNBALANCED   = 10;
  localparam int unsigned ST_PHASE_LOSS   = 13;
  localparam int unsigned ST_BAKEOUT      = 14;
  localparam int unsigned ST_THERM_LATCH  = 15;

  // Command word bit positions.
  localparam int unsigned CMD_LOCAL_SP  = 1;
  localparam int unsigned CMD_OUT_EN    = 2;
  localparam int unsigned CMD_LOCAL_ILM = 4;
  localparam logic [WORD_W-1:0] CMD_USED_MASK = 16'h0016;

  // Digital input used for enabling the output.
  typedef enum logic [1:0] {
    PCIR_DI_NONE,
    PCIR_DI_ONE,
    PCIR_DI_TWO
  } pcir_di_sel_t;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic              RST_BIT  = 1'b0;

endpackage

/* File: rtl/pcir_sync2.sv */
// Two-stage synchroniser for level inputs arriving from pins.
// Assumes the inputs are slow levels; no event is carried through it.
`timescale 1ns/1ns
module pcir_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ------------------------------------------------------------------
  // Stages
  // ------------------------------------------------------------------
  // The first stage may go metastable, so only the second stage reads it.
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;

endmodule // pcir_sync2

/* File: rtl/pcir_input_regs.sv */
// Read-only input word bank of a thyristor power controller.
// Assumes measurement words, alarms and the written command word come from
// logic on clk; the two digital inputs come straight from pins.
`timescale 1ns/1ns
module pcir_input_regs
  import pcir_pkg::*;
#(
  parameter int unsigned DI_COUNT = 2
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Fieldbus word read port.
  input  wire logic                rd_req,
  input  wire logic                rd_byte_mode,
  input  wire logic [ADDR_W-1:0]   rd_addr,
  output logic      [WORD_W-1:0]   rd_data,
  output logic                     rd_ack,
  output logic                     rd_err,
  // Measurements in fieldbus units.
  input  wire logic [WORD_W-1:0]   line_freq_in,
  input  wire logic [WORD_W-1:0]   out_volt_in,
  input  wire logic [WORD_W-1:0]   out_curr_in,
  input  wire logic [WORD_W-1:0]   out_power_in,
  input  wire logic [WORD_W-1:0]   setpoint_in,
  input  wire logic [WORD_W-1:0]   scale_in,
  // Command word as written by the master.
  input  wire logic [WORD_W-1:0]   cmd_word_in,
  input  wire logic                port_rw_access,
  input  wire logic [1:0]          di_enable_sel,
  // Alarm and state levels.
  input  wire logic                shorted_thyristor,
  input  wire logic                heater_break,
  input  wire logic                current_limit,
  input  wire logic                thermal_alarm,
  input  wire logic                comm_alarm,
  input  wire logic                unbalanced_load,
  input  wire logic                phase_loss,
  input  wire logic                bakeout_active,
  input  wire logic                thermal_latch_clr,
  // Digital input pins.
  input  wire logic [DI_COUNT-1:0] dig_in,
  // Output enable towards the firing logic.
  output logic                     power_enable
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  logic [DI_COUNT-1:0] dig_sync;

  pcir_sync2 #(
    .WIDTH (DI_COUNT)
  ) u_di_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (dig_in),
    .sync_out (dig_sync)
  );

  // ------------------------------------------------------------------
  // Saturating capture of measurement words
  // ------------------------------------------------------------------
  // Inputs beyond range are clamped rather than wrapped, so a master that
  // scales by the maximum never sees a small value for a large quantity.
  logic [WORD_W-1:0] line_freq_ff;
  logic [WORD_W-1:0] out_volt_ff;
  logic [WORD_W-1:0] out_curr_ff;
  logic [WORD_W-1:0] out_power_ff;
  logic [WORD_W-1:0] setpoint_ff;
  logic [WORD_W-1:0] scale_ff;
  logic [WORD_W-1:0] nxt_line_freq;
  logic [WORD_W-1:0] nxt_out_volt;
  logic [WORD_W-1:0] nxt_out_curr;
  logic [WORD_W-1:0] nxt_out_power;
  logic [WORD_W-1:0] nxt_setpoint;
  logic [WORD_W-1:0] nxt_scale;

  assign nxt_line_freq = (line_freq_in > MAX_LINE_FREQ) ? MAX_LINE_FREQ : line_freq_in;
  assign nxt_out_volt  = (out_volt_in  > MAX_OUT_VOLT)  ? MAX_OUT_VOLT  : out_volt_in;
  assign nxt_out_curr  = (out_curr_in  > MAX_OUT_CURR)  ? MAX_OUT_CURR  : out_curr_in;
  assign nxt_out_power = (out_power_in > MAX_OUT_POWER) ? MAX_OUT_POWER : out_power_in;
  assign nxt_setpoint  = (setpoint_in  > MAX_SETPOINT)  ? MAX_SETPOINT  : setpoint_in;
  assign nxt_scale     = (scale_in     > MAX_SCALE)     ? MAX_SCALE     : scale_in;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_freq_ff <= RST_WORD;
      out_volt_ff  <= RST_WORD;
      out_curr_ff  <= RST_WORD;
      out_power_ff <= RST_WORD;
      setpoint_ff  <= RST_WORD;
      scale_ff     <= RST_WORD;
    end else begin
      line_freq_ff <= nxt_line_freq;
      out_volt_ff  <= nxt_out_volt;
      out_curr_ff  <= nxt_out_curr;
      out_power_ff <= nxt_out_power;
      setpoint_ff  <= nxt_setpoint;
      scale_ff     <= nxt_scale;
    end
  end

  // ------------------------------------------------------------------
  // Command readback
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] cmd_rb_ff;
  logic [WORD_W-1:0] nxt_cmd_rb;

  // Only the local set point, enable and local current limit bits survive.
  assign nxt_cmd_rb = cmd_word_in & CMD_USED_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rb_ff <= RST_WORD;
    end else begin
      cmd_rb_ff <= nxt_cmd_rb;
    end
  end

  // ------------------------------------------------------------------
  // Output enable
  // ------------------------------------------------------------------
  // With read-write access the command bit and a configured enabling input
  // must both be on; without it the master cannot gate the output, so only
  // the enabling input (if any) decides.
  pcir_di_sel_t di_sel;
  logic         di_gate;
  logic         nxt_power_enable;
  logic         power_enable_ff;

  assign di_sel  = pcir_di_sel_t'(di_enable_sel);
  assign di_gate = (di_sel == PCIR_DI_ONE) ? dig_sync[0] :
                   (di_sel == PCIR_DI_TWO) ? dig_sync[1] : 1'b1;
  assign nxt_power_enable = port_rw_access ? (cmd_rb_ff[CMD_OUT_EN] & di_gate)
                                           : di_gate;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_enable_ff <= RST_BIT;
    end else begin
      power_enable_ff <= nxt_power_enable;
    end
  end

  assign power_enable = power_enable_ff;

  // ------------------------------------------------------------------
  // Alarm capture and thermal latch
  // ------------------------------------------------------------------
  logic [WORD_W-1:0] status_ff;
  logic [WORD_W-1:0] nxt_status;
  logic              therm_latch_ff;
  logic              nxt_therm_latch;

  // A thermal alarm present in the clearing cycle keeps the latch set.
  assign nxt_therm_latch = thermal_alarm | (therm_latch_ff & ~thermal_latch_clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_latch_ff <= RST_BIT;
    end else begin
      therm_latch_ff <= nxt_therm_latch;
    end
  end

  always_comb begin
    nxt_status                  = RST_WORD;
    nxt_status[ST_SHORTED_THYR] = shorted_thyristor;
    nxt_status[ST_HEATER_BREAK] = heater_break;
    nxt_status[ST_OUT_ENABLED]  = power_enable_ff;
    nxt_status[ST_CURR_LIMIT]   = current_limit;
    nxt_status[ST_THERMAL]      = thermal_alarm;
    nxt_status[ST_COMM_ALARM]   = comm_alarm;
    nxt_status[ST_DIG_IN1]      = dig_sync[0];
    nxt_status[ST_DIG_IN2]      = dig_sync[1];
    nxt_status[ST_UNBALANCED]   = unbalanced_load;
    nxt_status[ST_PHASE_LOSS]   = phase_loss;
    nxt_status[ST_BAKEOUT]      = bakeout_active;
    nxt_status[ST_THERM_LATCH]  = therm_latch_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= RST_WORD;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // In byte mode the word index is the byte offset halved; an odd byte
  // offset falls between words and is refused.
  logic [ADDR_W-1:0] word_idx;
  logic              odd_byte;
  logic              in_range;
  logic [WORD_W-1:0] sel_data;

  assign word_idx = rd_byte_mode ? (rd_addr >> BYTE_SHIFT) : rd_addr;
  assign odd_byte = rd_byte_mode & rd_addr[0];
  assign in_range = (word_idx < ADDR_W'(NUM_WORDS)) & ~odd_byte;

  always_comb begin
    sel_data = RST_WORD;
    unique case (word_idx)
      OFS_LINE_FREQ: sel_data = line_freq_ff;
      OFS_OUT_VOLT:  sel_data = out_volt_ff;
      OFS_OUT_CURR:  sel_data = out_curr_ff;
      OFS_OUT_POWER: sel_data = out_power_ff;
      OFS_STATUS:    sel_data = status_ff;
      OFS_CMD_RB:    sel_data = cmd_rb_ff;
      OFS_SETPOINT:  sel_data = setpoint_ff;
      OFS_SCALE:     sel_data = scale_ff;
      default:       sel_data = RST_WORD;
    endcase
    if (odd_byte) begin
      sel_data = RST_WORD;
    end
  end

  // ------------------------------------------------------------------
  // Read answer
  // ------------------------------------------------------------------
  // The answer follows the request by one clock; data holds until the
  // next request so a slow master may sample it late.
  logic [WORD_W-1:0] rd_data_ff;
  logic              rd_ack_ff;
  logic              rd_err_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= RST_WORD;
      rd_ack_ff  <= RST_BIT;
      rd_err_ff  <= RST_BIT;
    end else begin
      rd_ack_ff <= rd_req;
      if (rd_req) begin
        rd_data_ff <= sel_data;
        rd_err_ff  <= ~in_range;
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_ack  = rd_ack_ff;
  assign rd_err  = rd_err_ff;

endmodule // pcir_input_regs

/* File: verification/pcir_input_regs_props.sv */
// Checker for the read port and output enable of the input word bank.
// Assumes one clock and the ports of pcir_input_regs; attached by bind.
`timescale 1ns/1ns
module pcir_input_regs_props
  import pcir_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              rd_req,
  input wire logic              rd_byte_mode,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic              rd_ack,
  input wire logic              rd_err,
  input wire logic [WORD_W-1:0] cmd_word_in,
  input wire logic              port_rw_access,
  input wire logic [1:0]        di_enable_sel,
  input wire logic              shorted_thyristor,
  input wire logic              power_enable
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wrd = rd_req && !rd_byte_mode;

  a_ack_one_cycle: assert property (1'h1 |=> rd_ack == $past(rd_req))
    else $error("read ack not one cycle after request");
  a_unmapped_word: assert property (
    wrd && rd_addr >= NUM_WORDS |=> rd_err && rd_data == 16'h0000)
    else $error("unmapped word not refused");
  a_odd_byte: assert property (
    rd_req && rd_byte_mode && rd_addr[0] |=> rd_err && rd_data == 16'h0000)
    else $error("odd byte offset not refused");
  a_reserved_zero: assert property (
    wrd && rd_addr <= OFS_RSVD1 |=> !rd_err && rd_data == 16'h0000)
    else $error("reserved word not zero");
  a_data_holds: assert property (!rd_req |=> $stable(rd_data) && $stable(rd_err))
    else $error("read data changed without request");
  a_power_max: assert property (
    wrd && rd_addr == OFS_OUT_POWER |=> rd_data <= MAX_OUT_POWER)
    else $error("power word above its maximum");
  a_setpoint_byte: assert property (
    rd_req && rd_byte_mode && rd_addr == 8'h10 |=> !rd_err && rd_data <= MAX_SETPOINT)
    else $error("set point byte read wrong");
  a_status_unused: assert property (
    wrd && rd_addr == OFS_STATUS |=> (rd_data & 16'h1888) == 16'h0000)
    else $error("unused status bit set");
  a_cmd_unused: assert property (
    wrd && rd_addr == OFS_CMD_RB |=> (rd_data & ~CMD_USED_MASK) == 16'h0000)
    else $error("unused command bit set");
  a_short_status: assert property (
    wrd && rd_addr == OFS_STATUS |=> rd_data[ST_SHORTED_THYR] == $past(shorted_thyristor, 2))
    else $error("status bit 0 wrong");
  a_cmd_enable: assert property (
    port_rw_access && di_enable_sel == 2'h0 ##1 port_rw_access && di_enable_sel == 2'h0
    |=> power_enable == $past(cmd_word_in[CMD_OUT_EN], 2))
    else $error("output enable does not follow command");
endmodule // pcir_input_regs_props

bind pcir_input_regs pcir_input_regs_props u_props (.clk, .rst_n, .rd_req, .rd_byte_mode,
  .rd_addr, .rd_data, .rd_ack, .rd_err, .cmd_word_in, .port_rw_access, .di_enable_sel,
  .shorted_thyristor, .power_enable);

/* File: verification/pcir_fieldbus_master.sv */
// Fieldbus master model that reads words from the input bank.
// Assumes the bench calls read() from a point just after a falling edge.
`timescale 1ns/1ns
module pcir_fieldbus_master
  import pcir_pkg::*;
(
  input  wire logic              clk,
  output logic                   rd_req,
  output logic                   rd_byte_mode,
  output logic      [ADDR_W-1:0] rd_addr,
  input  wire logic [WORD_W-1:0] rd_data,
  input  wire logic              rd_ack,
  input  wire logic              rd_err
);
  // ------------------------------------------------------------------
  // Read cycle
  // ------------------------------------------------------------------
  initial begin
    rd_req = 1'h0;
    rd_byte_mode = 1'h0;
    rd_addr = 8'h00;
  end

  // The request is a one-cycle pulse; a held request would read twice.
  task automatic read(input logic bm, input logic [ADDR_W-1:0] a,
                      output logic [WORD_W-1:0] d, output logic e, output logic ok);
    int n;
    n = 0;
    @(negedge clk);
    rd_req = 1'h1;
    rd_byte_mode = bm;
    rd_addr = a;
    @(negedge clk);
    rd_req = 1'h0;
    while (rd_ack !== 1'h1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    ok = (rd_ack === 1'h1) && (n == 0);
    d = rd_data;
    e = rd_err;
    rd_addr = ~a;
  endtask
endmodule // pcir_fieldbus_master

/* File: verification/test_power_controller_input_regs.sv */
// Self-checking bench for the input word bank.
// Assumes the master model for reads; inputs change at the falling edge.
`timescale 1ns/1ns
module test_power_controller_input_regs import pcir_pkg::*;;
  logic              clk = 1'h0;
  logic              rst_n = 1'h0;
  logic [WORD_W-1:0] meas [6] = '{default: 16'h0000};
  logic [WORD_W-1:0] cmd = 16'h0000;
  logic [7:0]        alm = 8'h00;
  logic              rw = 1'h1;
  logic              clr = 1'h0;
  logic [1:0]        sel = 2'h0;
  logic [1:0]        din = 2'h0;
  wire logic [WORD_W-1:0] rd_data;
  wire logic [ADDR_W-1:0] rd_addr;
  wire logic              rd_req, rd_byte_mode, rd_ack, rd_err, power_enable;
  int                n_mismatch = 0;
  int                total_checks = 0;

  always #4 clk = ~clk;

  pcir_fieldbus_master master (.clk, .rd_req, .rd_byte_mode, .rd_addr, .rd_data, .rd_ack,
    .rd_err);
  pcir_input_regs dut (.clk, .rst_n, .rd_req, .rd_byte_mode, .rd_addr, .rd_data, .rd_ack,
    .rd_err, .line_freq_in(meas[0]), .out_volt_in(meas[1]), .out_curr_in(meas[2]),
    .out_power_in(meas[3]), .setpoint_in(meas[4]), .scale_in(meas[5]), .cmd_word_in(cmd),
    .port_rw_access(rw), .di_enable_sel(sel), .shorted_thyristor(alm[0]),
    .heater_break(alm[1]), .current_limit(alm[2]), .comm_alarm(alm[3]),
    .unbalanced_load(alm[4]), .phase_loss(alm[5]), .bakeout_active(alm[6]),
    .thermal_alarm(alm[7]), .thermal_latch_clr(clr), .dig_in(din), .power_enable);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic bm, input logic [ADDR_W-1:0] a,
                    input logic [WORD_W-1:0] exp, input logic err);
    logic [WORD_W-1:0] d;
    logic              e, ok;
    master.read(bm, a, d, e, ok);
    check("read ack", {15'h0000, ok}, 16'h0001);
    check($sformatf("word at %h", a), d, exp);
    check("read error", {15'h0000, e}, {15'h0000, err});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_words();
    for (int a = 0; a < 10; a++) rd(1'h0, a[7:0], 16'h0000, 1'h0);
  endtask

  task automatic t_measure();
    logic [WORD_W-1:0] lim [6] = '{MAX_LINE_FREQ, MAX_OUT_VOLT, MAX_OUT_CURR, MAX_OUT_POWER,
                                   MAX_SETPOINT, MAX_SCALE};
    logic [ADDR_W-1:0] ofs [6] = '{OFS_LINE_FREQ, OFS_OUT_VOLT, OFS_OUT_CURR, OFS_OUT_POWER,
                                   OFS_SETPOINT, OFS_SCALE};
    for (int i = 0; i < 6; i++) begin
      meas[i] = lim[i] - 16'h0001;
      rd(1'h1, ofs[i] << BYTE_SHIFT, lim[i] - 16'h0001, 1'h0);
      meas[i] = 16'hFFFF;
      rd(1'h0, ofs[i], lim[i], 1'h0);
      meas[i] = 16'h0000;
      rd(1'h0, ofs[i], 16'h0000, 1'h0);
    end
  endtask

  task automatic t_status();
    int unsigned pos [8] = '{ST_SHORTED_THYR, ST_HEATER_BREAK, ST_CURR_LIMIT, ST_COMM_ALARM,
                             ST_UNBALANCED, ST_PHASE_LOSS, ST_BAKEOUT, ST_THERMAL};
    for (int i = 0; i < 8; i++) begin
      alm = 8'h01 << i;
      @(negedge clk);
      rd(1'h0, OFS_STATUS, (16'h0001 << pos[i]) | (i == 7 ? 16'h8000 : 16'h0000), 1'h0);
    end
    alm = 8'h00;
    @(negedge clk);
    rd(1'h0, OFS_STATUS, 16'h0001 << ST_THERM_LATCH, 1'h0);
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
    rd(1'h0, OFS_STATUS, 16'h0000, 1'h0);
    // An alarm in the clearing cycle must leave the latch set.
    alm = 8'h80;
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
    alm = 8'h00;
    rd(1'h0, OFS_STATUS, 16'h8000, 1'h0);
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
    rd(1'h0, OFS_STATUS, 16'h0000, 1'h0);
    din = 2'h3;
    repeat (4) @(negedge clk);
    rd(1'h0, OFS_STATUS, 16'h0300, 1'h0);
    din = 2'h2;
    repeat (4) @(negedge clk);
    rd(1'h0, OFS_STATUS, 16'h0200, 1'h0);
    din = 2'h0;
  endtask

  task automatic t_command();
    cmd = 16'hFFFF;
    rd(1'h0, OFS_CMD_RB, CMD_USED_MASK, 1'h0);
    cmd = 16'h0002;
    rd(1'h0, OFS_CMD_RB, 16'h0002, 1'h0);
    cmd = 16'h0010;
    rd(1'h0, OFS_CMD_RB, 16'h0010, 1'h0);
    cmd = 16'h0004;
    repeat (2) @(negedge clk);
    check("output enable", {15'h0000, power_enable}, 16'h0001);
    @(negedge clk);
    rd(1'h0, OFS_STATUS, 16'h0004, 1'h0);
    cmd = 16'h0000;
    repeat (3) @(negedge clk);
    rd(1'h0, OFS_STATUS, 16'h0000, 1'h0);
  endtask

  task automatic t_enable_di();
    for (int s = 1; s < 3; s++) begin
      sel = s[1:0];
      cmd = 16'h0004;
      repeat (6) @(negedge clk);
      check("enable input off", {15'h0000, power_enable}, 16'h0000);
      din = s[1:0];
      repeat (6) @(negedge clk);
      check("enable both on", {15'h0000, power_enable}, 16'h0001);
      cmd = 16'h0000;
      repeat (6) @(negedge clk);
      check("enable command off", {15'h0000, power_enable}, 16'h0000);
      din = 2'h0;
    end
    sel = 2'h0;
    // Without read-write access the command is ignored and the input decides.
    rw = 1'h0;
    repeat (3) @(negedge clk);
    check("enable no access", {15'h0000, power_enable}, 16'h0001);
    sel = 2'h3;
    repeat (3) @(negedge clk);
    check("enable code three", {15'h0000, power_enable}, 16'h0001);
    sel = 2'h1;
    repeat (6) @(negedge clk);
    check("enable input only", {15'h0000, power_enable}, 16'h0000);
    sel = 2'h0;
    rw = 1'h1;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_refuse();
    rd(1'h0, 8'h0A, 16'h0000, 1'h1);
    rd(1'h0, 8'hFF, 16'h0000, 1'h1);
    rd(1'h1, 8'h05, 16'h0000, 1'h1);
    rd(1'h1, 8'h14, 16'h0000, 1'h1);
    rd(1'h1, 8'h02, 16'h0000, 1'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Ends the run as a failure after 20000 clocks if the scenarios have not finished.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    t_reset_words();
    t_measure();
    t_status();
    t_command();
    t_enable_di();
    t_refuse();
    results();
  end
endmodule // test_power_controller_input_regs
